// ---- ilc_link_ctrl.sv ----
// Control plane of the infrared serial controller: registers, mode select,
// pin routing, polarity, loopback, underrun policy and receive filtering.
// Assumes the decoders and encoders sit outside and run from mclk enables.
module ilc_link_ctrl #(
	parameter int FIFO_DEPTH = 16
) (
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        rst_b,
	// Peripheral bus slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// System pin routing.
	input  wire logic        ir_pin_drive,
	input  wire logic        uart_tx,
	input  wire logic        uart_sir_tx,
	output logic             txd_pin,
	input  wire logic        rxd_pin,
	// Encoder select and settings towards the shared MIR/FIR modules.
	output logic             sir_sel,
	output logic             mir_sel,
	output logic             fir_sel,
	output logic             medium_rate_pick,
	output logic             tx_run,
	output logic             rx_run,
	// Serial path to the encoders and decoders.
	input  wire logic        tx_encoded,
	input  wire logic        tx_shift_bit,
	output logic             rx_serial,
	// Transmit status from the encoders, and the underrun responses sent back to them.
	input  wire logic        mir_tx_in_frame,
	input  wire logic        fir_tx_in_frame,
	input  wire logic        tx_aborting,
	input  wire logic        tx_underrun,
	output logic             tx_end_frame,
	output logic             tx_abort,
	// Received bytes from the decoder.
	input  wire logic        rx_byte_valid,
	output logic             rx_byte_ready,
	input  wire logic        rx_byte_first,
	input  wire logic        rx_byte_last,
	input  wire logic [7:0]  rx_byte,
	// Accepted bytes towards the data register or DMA.
	output logic             rx_out_valid,
	input  wire logic        rx_out_ready,
	output logic      [8:0]  rx_out_data
);
	// Enable register fields.
	ilc_pkg::ilc_mode_t mode_reg;        // Selected encoder.
	logic               loop_back_reg;   // Loopback for MIR and FIR.
	logic               medium_tx_done_reg;
	logic               fast_tx_done_reg;
	// Control register fields.
	logic               rate_reg;
	logic               underrun_action_reg;
	logic               send_on_reg;
	logic               receive_on_reg;
	logic               send_invert_reg;
	logic               receive_invert_reg;
	logic               addr_filter_on_reg;
	// Match value.
	logic [7:0]         addr_filter_value_reg;
	// Bus decode and other internal nets.
	logic               wr_en;
	logic               rd_setup;
	logic               hit_en;
	logic               hit_ct;
	logic               hit_mv;
	logic               hit_fl;
	logic               fast_mode;
	logic               sender_active;
	logic               ir_out;
	logic               keep;
	logic               fifo_in_ready;
	logic               fifo_push;
	logic               fifo_clear;

	// Address decode; the slave never inserts wait states.
	assign hit_en   = (paddr == ilc_pkg::ENABLE_ADDR);
	assign hit_ct   = (paddr == ilc_pkg::CONTROL_ADDR);
	assign hit_mv   = (paddr == ilc_pkg::MATCH_ADDR);
	assign hit_fl   = (paddr == ilc_pkg::FLAGS_ADDR);
	assign wr_en    = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign pready   = 1'b1;
	// Unmapped addresses answer with an error in the access phase.
	assign pslverr  = psel && penable && !(hit_en || hit_ct || hit_mv || hit_fl);

	// MIR and FIR share one control set; only the mode decides who listens. [RQ3]
	assign fast_mode = (mode_reg == ilc_pkg::MODE_MIR) || (mode_reg == ilc_pkg::MODE_FIR);

	// Enable register; the mode may be rewritten any time, software keeps
	// both enables clear first so no frame is cut mid-way. [RQ8]
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mode_reg      <= ilc_pkg::ilc_mode_t'(ilc_pkg::ENABLE_RESET[1:0]);
			loop_back_reg <= ilc_pkg::ENABLE_RESET[ilc_pkg::EN_LOOP];
		end
		else if (wr_en && hit_en)
		begin
			mode_reg      <= ilc_pkg::ilc_mode_t'(pwdata[ilc_pkg::EN_MODE_LO +: 2]); // [RQ2]
			loop_back_reg <= pwdata[ilc_pkg::EN_LOOP];
		end
	end

	// Control register; every field but the enables takes effect at once. [RQ9]
	// Bit 0 is not stored, so it always reads zero. [RQ17]
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rate_reg            <= ilc_pkg::CONTROL_RESET[ilc_pkg::CT_RATE];
			underrun_action_reg <= ilc_pkg::CONTROL_RESET[ilc_pkg::CT_UNDER];
			send_on_reg         <= ilc_pkg::CONTROL_RESET[ilc_pkg::CT_SEND];
			receive_on_reg      <= ilc_pkg::CONTROL_RESET[ilc_pkg::CT_RECV];
			send_invert_reg     <= ilc_pkg::CONTROL_RESET[ilc_pkg::CT_TXINV];
			receive_invert_reg  <= ilc_pkg::CONTROL_RESET[ilc_pkg::CT_RXINV];
			addr_filter_on_reg  <= ilc_pkg::CONTROL_RESET[ilc_pkg::CT_FILTER];
		end
		else if (wr_en && hit_ct)
		begin
			rate_reg            <= pwdata[ilc_pkg::CT_RATE];
			underrun_action_reg <= pwdata[ilc_pkg::CT_UNDER];
			send_on_reg         <= pwdata[ilc_pkg::CT_SEND];
			receive_on_reg      <= pwdata[ilc_pkg::CT_RECV];
			send_invert_reg     <= pwdata[ilc_pkg::CT_TXINV];
			receive_invert_reg  <= pwdata[ilc_pkg::CT_RXINV];
			addr_filter_on_reg  <= pwdata[ilc_pkg::CT_FILTER];
		end
	end

	// Match value may change mid-reception; the filter reads it live. [RQ20]
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			addr_filter_value_reg <= ilc_pkg::MATCH_RESET[7:0];
		end
		else if (wr_en && hit_mv)
		begin
			addr_filter_value_reg <= pwdata[7:0];
		end
	end

	// Done bits each belong to their own module, kept apart. [RQ3]
	// Low while that module's transmitter is enabled, high once it is not. [RQ4] [RQ5]
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			medium_tx_done_reg <= ilc_pkg::ENABLE_RESET[ilc_pkg::EN_MED_DONE];
			fast_tx_done_reg   <= ilc_pkg::ENABLE_RESET[ilc_pkg::EN_FAST_DONE];
		end
		else
		begin
			medium_tx_done_reg <= !(send_on_reg && mode_reg == ilc_pkg::MODE_MIR); // [RQ5]
			fast_tx_done_reg   <= !(send_on_reg && mode_reg == ilc_pkg::MODE_FIR); // [RQ4]
		end
	end

	// Busy only while a frame goes out; idle, disabled and abort read zero.
	// Software polls this before dropping the transmit enable. [RQ6]
	assign sender_active = send_on_reg && !tx_aborting                          // [RQ22]
	                       && ((mode_reg == ilc_pkg::MODE_MIR && mir_tx_in_frame)
	                       ||  (mode_reg == ilc_pkg::MODE_FIR && fir_tx_in_frame));

	// Read data is captured in the setup phase so it is a flop in the access phase.
	// Reserved bits read zero; software must not rely on them. [RQ23]
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			prdata <= 32'h0000_0000;
		end
		else if (rd_setup)
		begin
			prdata <= 32'h0000_0000;
			if (hit_en)
			begin
				prdata[1:0]                    <= mode_reg;
				prdata[ilc_pkg::EN_LOOP]       <= loop_back_reg;
				prdata[ilc_pkg::EN_MED_DONE]   <= medium_tx_done_reg;
				prdata[ilc_pkg::EN_FAST_DONE]  <= fast_tx_done_reg;
			end
			else if (hit_ct)
			begin
				prdata[ilc_pkg::CT_RATE]   <= rate_reg;
				prdata[ilc_pkg::CT_UNDER]  <= underrun_action_reg;
				prdata[ilc_pkg::CT_SEND]   <= send_on_reg;
				prdata[ilc_pkg::CT_RECV]   <= receive_on_reg;
				prdata[ilc_pkg::CT_TXINV]  <= send_invert_reg;
				prdata[ilc_pkg::CT_RXINV]  <= receive_invert_reg;
				prdata[ilc_pkg::CT_FILTER] <= addr_filter_on_reg;
			end
			else if (hit_mv)
			begin
				prdata[7:0] <= addr_filter_value_reg;
			end
			else if (hit_fl)
			begin
				prdata[ilc_pkg::FL_BUSY] <= sender_active;
			end
		end
	end

	// Encoder selection straight from the mode code. [RQ2]
	assign sir_sel          = (mode_reg == ilc_pkg::MODE_SIR);
	assign mir_sel          = (mode_reg == ilc_pkg::MODE_MIR);
	assign fir_sel          = (mode_reg == ilc_pkg::MODE_FIR);
	// Zero picks 0.576 Mbit/s, one picks 1.152 Mbit/s. [RQ16]
	assign medium_rate_pick = rate_reg;
	// These enables gate the encoder and decoder clocks off. [RQ13] [RQ14]
	assign tx_run           = send_on_reg && fast_mode;
	assign rx_run           = receive_on_reg && fast_mode;

	// Encoded output, inverted on request and silent while disabled. [RQ12] [RQ14]
	assign ir_out = tx_run && (tx_encoded ^ send_invert_reg);

	// Pin routing and receive path are registered to keep the pin glitch free.
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			txd_pin   <= 1'b0;
			rx_serial <= 1'b0;
		end
		else
		begin
			txd_pin <= ir_pin_drive ? (ir_out | uart_sir_tx) : uart_tx;          // [RQ1]
			if (!rx_run)
			begin
				rx_serial <= 1'b0;                                           // [RQ13]
			end
			else if (loop_back_reg)
			begin
				rx_serial <= tx_shift_bit;                                   // [RQ7]
			end
			else
			begin
				rx_serial <= rxd_pin ^ receive_invert_reg;                   // [RQ11]
			end
		end
	end

	// Underrun policy: normal close (CRC, stop flag, pulse) or abort. [RQ15]
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tx_end_frame <= 1'b0;
			tx_abort     <= 1'b0;
		end
		else
		begin
			tx_end_frame <= tx_run && tx_underrun && !underrun_action_reg;      // [RQ15]
			tx_abort     <= tx_run && tx_underrun && underrun_action_reg;       // [RQ15]
		end
	end

	// Filter decides frame by frame; rejected bytes are drained and dropped.
	ilc_addr_filter u_filter (
		.mclk        (mclk),
		.rst_b       (rst_b),
		.filter_on   (addr_filter_on_reg),
		.match_value (addr_filter_value_reg),
		.byte_take   (rx_byte_valid && rx_byte_ready),
		.byte_first  (rx_byte_first),
		.byte_data   (rx_byte),
		.keep        (keep)
	);

	// A full FIFO stalls the decoder, but a rejected byte never waits.
	assign fifo_push     = rx_byte_valid && keep && rx_run;                // [RQ10]
	assign rx_byte_ready = !rx_run || !keep || fifo_in_ready;
	// Dropping the receive enable flushes whatever was buffered. [RQ13]
	assign fifo_clear    = !receive_on_reg;

	ilc_fifo #(
		.WIDTH (9),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk      (mclk),
		.rst_b     (rst_b),
		.clear     (fifo_clear),
		.in_valid  (fifo_push),
		.in_ready  (fifo_in_ready),
		.in_data   ({rx_byte_last, rx_byte}),
		.out_valid (rx_out_valid),
		.out_ready (rx_out_ready),
		.out_data  (rx_out_data)
	);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	property p_pin_route;  // [RQ1]
		$past(ir_pin_drive) && $past(!tx_run) |-> txd_pin == $past(uart_sir_tx);
	endproperty
	a_pin_route: assert property (p_pin_route) else $error("pin routing wrong");

	property p_mode_sel;  // [RQ2]
		$countones({sir_sel, mir_sel, fir_sel}) == ((mode_reg == ilc_pkg::MODE_OFF) ? 0 : 1);
	endproperty
	a_mode_sel: assert property (p_mode_sel) else $error("encoder select wrong");

	property p_fast_done;  // [RQ4]
		send_on_reg && fir_sel |=> !fast_tx_done_reg;
	endproperty
	a_fast_done: assert property (p_fast_done) else $error("fast done high while enabled");

	property p_med_done;  // [RQ5]
		!send_on_reg ##1 !send_on_reg |-> medium_tx_done_reg && fast_tx_done_reg;
	endproperty
	a_med_done: assert property (p_med_done) else $error("done bit low after disable");

	property p_loop;  // [RQ7]
		rx_run && loop_back_reg |=> rx_serial == $past(tx_shift_bit);
	endproperty
	a_loop: assert property (p_loop) else $error("loopback path wrong");

	property p_filter;  // [RQ10]
		fifo_push && fifo_in_ready && rx_byte_first && addr_filter_on_reg
		|-> rx_byte == addr_filter_value_reg || rx_byte == ilc_pkg::BROADCAST;
	endproperty
	a_filter: assert property (p_filter) else $error("foreign frame stored");

	property p_rx_off;  // [RQ13]
		!receive_on_reg |=> !rx_out_valid && !rx_serial;
	endproperty
	a_rx_off: assert property (p_rx_off) else $error("receive active while off");

	property p_underrun;  // [RQ15]
		tx_run && tx_underrun |=> (tx_abort == $past(underrun_action_reg)) && (tx_end_frame != tx_abort);
	endproperty
	a_underrun: assert property (p_underrun) else $error("underrun policy wrong");

	property p_busy;  // [RQ22]
		sender_active |-> send_on_reg && !tx_aborting;
	endproperty
	a_busy: assert property (p_busy) else $error("busy while idle or aborting");

	c_fir_send: cover property (fir_sel && send_on_reg && sender_active);
	c_abort:    cover property (tx_abort);
	c_full:     cover property (rx_byte_valid && keep && !fifo_in_ready);
	c_loop:     cover property (rx_run && loop_back_reg);

endmodule // ilc_link_ctrl

// ---- ilc_pkg.sv ----
// Shared constants and types of the infrared link control block.
// Assumes a single clock domain and register access over the peripheral bus.
// How it works
// RQ1: Pin carries IR OR SIR when drive set.
// RQ2: Mode code picks none, SIR, MIR or FIR.
// RQ3: MIR and FIR share controls, separate status.
// RQ4: Fast done low while FIR transmit enabled.
// RQ5: Medium done low while MIR transmit enabled.
// RQ6: Software polls busy before clearing transmit.
// RQ7: Loopback joins transmit shifter to receive shifter.
// RQ8: Software clears enables before changing mode.
// RQ9: Other control fields change while active.
// RQ10: Filter on stores only matching or broadcast frames.
// RQ11: Receive invert flips serial input before decoding.
// RQ12: Send invert flips encoded output to pin.
// RQ13: Receive enable low stops receive logic.
// RQ14: Transmit enable low stops transmit logic.
// RQ15: Underrun sends CRC/stop/pulse, or an abort.
// RQ16: Rate pick selects 0.576 or 1.152 Mbit/s.
// RQ17: Software writes zero to control bit zero.
// RQ18: Matching frames stored, others skipped entirely.
// RQ19: All-ones address is broadcast, always accepted.
// RQ20: Match value rewritable any time, used next.
// RQ21: DMA packs bytes into 32-bit words.
// RQ22: Busy flag high only while sending frame.
// RQ23: Software writes zero to reserved bits.
package ilc_pkg;

	// Byte addresses of the registers.
	localparam logic [31:0] ENABLE_ADDR  = 32'h808b_0000;
	localparam logic [31:0] CONTROL_ADDR = 32'h808b_0004;
	localparam logic [31:0] MATCH_ADDR   = 32'h808b_0008;
	localparam logic [31:0] FLAGS_ADDR   = 32'h808b_000c;

	// Reset values.
	localparam logic [31:0] ENABLE_RESET  = 32'h0000_0018;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
	localparam logic [31:0] MATCH_RESET   = 32'h0000_0000;

	// Field positions of the enable register.
	localparam int EN_MODE_LO   = 0;
	localparam int EN_LOOP      = 2;
	localparam int EN_MED_DONE  = 3;
	localparam int EN_FAST_DONE = 4;

	// Field positions of the control register; bit 0 always reads zero.
	localparam int CT_RATE   = 1;
	localparam int CT_UNDER  = 2;
	localparam int CT_SEND   = 3;
	localparam int CT_RECV   = 4;
	localparam int CT_TXINV  = 5;
	localparam int CT_RXINV  = 6;
	localparam int CT_FILTER = 7;

	// Field position of the busy bit in the flag register.
	localparam int FL_BUSY = 9;

	// Width of the address match field and the broadcast address.
	localparam int          ADDR_W    = 8;
	localparam logic [7:0]  BROADCAST = 8'hff;

	// Encoder selection, in the order of the two-bit mode code.
	typedef enum logic [1:0] {MODE_OFF, MODE_SIR, MODE_MIR, MODE_FIR} ilc_mode_t;

endpackage : ilc_pkg

// ---- ilc_fifo.sv ----
// Synchronous FIFO holding accepted receive bytes.
// Assumes DEPTH is a power of two; clear empties it in one cycle.
module ilc_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	// Clock and reset.
	input  wire logic             mclk,
	input  wire logic             rst_b,
	input  wire logic             clear,
	// Filling side.
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side.
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];  // Storage, no reset needed.
	logic [AW-1:0]    wr_ptr_reg;   // Next slot to write.
	logic [AW-1:0]    rd_ptr_reg;   // Oldest entry.
	logic [AW:0]      count_reg;    // Entries held.
	logic             push;
	logic             pop;

	// Full and empty come straight from the count, so they never lie.
	assign in_ready  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data  = mem[rd_ptr_reg];
	assign push      = in_valid && in_ready && !clear;
	assign pop       = out_valid && out_ready && !clear;

	// Storage write.
	always_ff @(posedge mclk)
	begin
		if (push)
		begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	// Pointers and count; clear wins over any transfer.
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else if (clear)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			wr_ptr_reg <= wr_ptr_reg + AW'(push);
			rd_ptr_reg <= rd_ptr_reg + AW'(pop);
			count_reg  <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule // ilc_fifo

// ---- ilc_addr_filter.sv ----
// Receive address filter: decides per frame whether its bytes are kept.
// Assumes the decoder marks the address byte of each frame as first.
module ilc_addr_filter (
	// Clock and reset.
	input  wire logic       mclk,
	input  wire logic       rst_b,
	// Settings.
	input  wire logic       filter_on,
	input  wire logic [7:0] match_value,
	// Byte being offered.
	input  wire logic       byte_take,
	input  wire logic       byte_first,
	input  wire logic [7:0] byte_data,
	// Verdict for the offered byte.
	output logic            keep
);
	logic keep_reg;  // Verdict latched from the frame's address byte.
	logic hit;       // Address byte would be accepted.

	// The live match value is compared, so a rewrite acts on the next frame. [RQ20]
	assign hit  = !filter_on || (byte_data == match_value)   // [RQ10] [RQ18]
	              || (byte_data == ilc_pkg::BROADCAST);      // [RQ19]
	assign keep = byte_first ? hit : keep_reg;

	// Hold the verdict so the rest of a rejected frame is skipped. [RQ18]
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			keep_reg <= 1'b1;
		end
		else if (byte_take && byte_first)
		begin
			keep_reg <= hit;
		end
	end

endmodule // ilc_addr_filter

// ---- ilc_far_model.sv ----
// Far-side byte source standing in for the decoder and the remote sender.
// Assumes the bench calls send_frame and the block's ready is combinational.
module ilc_far_model (
	// Clock and reset.
	input  wire logic       mclk,
	input  wire logic       rst_b,
	// Byte stream towards the block.
	output logic            rx_byte_valid = 1'b0,
	input  wire logic       rx_byte_ready,
	output logic            rx_byte_first = 1'b0,
	output logic            rx_byte_last  = 1'b0,
	output logic      [7:0] rx_byte       = 8'h00
);
	timeunit 1ns;
	timeprecision 1ps;

	// Sends one frame: the address byte first, then address plus index.
	// Each byte is held until an edge that sees ready high, as a real decoder must.
	task automatic send_frame(input logic [7:0] addr, input int n);
		int i;
		@(posedge mclk);
		for (i = 0; i < n; i++)
		begin
			rx_byte_valid <= 1'b1;
			rx_byte_first <= (i == 0);
			rx_byte_last  <= (i == n - 1);
			rx_byte       <= addr + 8'(i);
			#1;
			while (rx_byte_ready !== 1'b1)
			begin
				@(posedge mclk);
				#1;
			end
			@(posedge mclk);
		end
		// A released data line shows the inverse of its last value, never a hold.
		rx_byte_valid <= 1'b0;
		rx_byte_first <= 1'b0;
		rx_byte_last  <= 1'b0;
		rx_byte       <= ~rx_byte;
	endtask
endmodule // ilc_far_model

// ---- infrared_link_control_bench.sv ----
// Self-checking bench for the infrared link control block.
// Assumes the far-side byte model; bus, pins and encoder status are driven here.
module infrared_link_control_bench;
	timeunit 1ns;
	timeprecision 1ps;

	// Bench-driven inputs, all quiet at time zero.
	logic        mclk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] paddr = '0, pwdata = '0;
	logic        ir_pin_drive = 1'b0, uart_tx = 1'b0, uart_sir_tx = 1'b0, rxd_pin = 1'b0;
	logic        tx_encoded = 1'b0, tx_shift_bit = 1'b0, mir_tx_in_frame = 1'b0;
	logic        fir_tx_in_frame = 1'b0, tx_aborting = 1'b0, tx_underrun = 1'b0;
	logic        rx_out_ready = 1'b0;
	// Design outputs and model lines.
	logic [31:0] prdata, rd_data;
	logic        pready, pslverr, txd_pin, sir_sel, mir_sel, fir_sel, medium_rate_pick;
	logic        tx_run, rx_run, rx_serial, tx_end_frame, tx_abort, rd_err;
	logic        rx_byte_valid, rx_byte_ready, rx_byte_first, rx_byte_last, rx_out_valid;
	logic [7:0]  rx_byte;
	logic [8:0]  rx_out_data;
	// Entries expected out of the buffer, in order, and the tallies.
	logic [8:0]  exp_q[$];
	int          fail_count = 0, n_compared = 0;

	ilc_link_ctrl #(.FIFO_DEPTH(16)) dut_u (
		.mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .ir_pin_drive, .uart_tx, .uart_sir_tx, .txd_pin, .rxd_pin, .sir_sel,
		.mir_sel, .fir_sel, .medium_rate_pick, .tx_run, .rx_run, .tx_encoded,
		.tx_shift_bit, .rx_serial, .mir_tx_in_frame, .fir_tx_in_frame, .tx_aborting,
		.tx_underrun, .tx_end_frame, .tx_abort, .rx_byte_valid, .rx_byte_ready,
		.rx_byte_first, .rx_byte_last, .rx_byte, .rx_out_valid, .rx_out_ready,
		.rx_out_data
	);
	ilc_far_model far_u (
		.mclk, .rst_b, .rx_byte_valid, .rx_byte_ready, .rx_byte_first, .rx_byte_last,
		.rx_byte
	);

	// The 100 MHz clock.
	always #5 mclk = ~mclk;

	// Prints the verdict and ends the run; the watchdog uses it too.
	task automatic complete_run();
		if (fail_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Compares one value; a mismatch is reported at once and counted.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// Lets n edges pass and lands just after the last one.
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// One bus transfer at offset off from the enable register: setup, then access.
	task automatic apb(input logic w, input logic [7:0] off, input logic [31:0] d);
		@(posedge mclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= ilc_pkg::ENABLE_ADDR + 32'(off);
		pwdata  <= d;
		@(posedge mclk);
		penable <= 1'b1;
		#1;
		rd_err = pslverr;
		chk(pready, 1);
		@(posedge mclk);
		psel    <= 1'b0;
		penable <= 1'b0;
		#1;
		rd_data = prdata;
	endtask

	// Reset values, read-only done bits, control readback with bit zero left clear, an unmapped place.
	task automatic s_regs();
		apb(0, 8'h00, 0);
		chk(rd_data, ilc_pkg::ENABLE_RESET);
		apb(0, 8'h04, 0);
		chk(rd_data, ilc_pkg::CONTROL_RESET);
		apb(0, 8'h08, 0);
		chk(rd_data, ilc_pkg::MATCH_RESET);
		apb(1, 8'h00, 0);
		apb(0, 8'h00, 0);
		chk(rd_data, 32'h0000_0018);
		apb(1, 8'h04, 32'h0000_00e6);
		apb(0, 8'h04, 0);
		chk(rd_data, 32'h0000_00e6);
		apb(1, 8'h04, 0);
		apb(0, 8'h10, 0);
		chk(rd_err, 1);
		chk(rd_data, 32'h0000_0000);
	endtask

	// Every mode code and both medium rates.
	task automatic s_mode();
		int m;
		for (m = 0; m < 4; m++)
		begin
			apb(1, 8'h00, 32'(m));
			chk({sir_sel, mir_sel, fir_sel}, {m == 1, m == 2, m == 3});
		end
		apb(1, 8'h04, 32'h0000_0002);
		chk(medium_rate_pick, 1);
		apb(1, 8'h04, 0);
		chk(medium_rate_pick, 0);
	endtask

	// Done bits and busy flag while sending in each of the medium and fast modes.
	task automatic s_done();
		int m;
		for (m = 2; m < 4; m++)
		begin
			apb(1, 8'h04, 0);
			apb(1, 8'h00, 32'(m));
			apb(1, 8'h04, 32'h0000_0008);
			apb(0, 8'h00, 0);
			chk(rd_data, (m == 2) ? 32'h0000_0012 : 32'h0000_000b);
			chk(tx_run, 1);
			@(posedge mclk);
			mir_tx_in_frame <= (m == 2);
			fir_tx_in_frame <= (m == 3);
			apb(0, 8'h0c, 0);
			chk(rd_data[ilc_pkg::FL_BUSY], 1);
			@(posedge mclk);
			tx_aborting <= 1'b1;
			apb(0, 8'h0c, 0);
			chk(rd_data[ilc_pkg::FL_BUSY], 0);
			@(posedge mclk);
			tx_aborting     <= 1'b0;
			mir_tx_in_frame <= 1'b0;
			fir_tx_in_frame <= 1'b0;
			// Software waits for the frame to leave before clearing the enable.
			apb(0, 8'h0c, 0);
			chk(rd_data[ilc_pkg::FL_BUSY], 0);
			apb(1, 8'h04, 0);
			apb(0, 8'h00, 0);
			chk(rd_data, 32'(m) | 32'h0000_0018);
			chk(tx_run, 0);
		end
	endtask

	// Pin routing and send polarity over all encoded, SIR, drive and invert combinations, fast mode sending.
	task automatic s_pin();
		int k;
		apb(1, 8'h04, 32'h0000_0008);
		for (k = 0; k < 16; k++)
		begin
			if (k[2:0] == 3'd0)
				apb(1, 8'h04, k[3] ? 32'h0000_0028 : 32'h0000_0008);
			@(posedge mclk);
			tx_encoded   <= k[0];
			uart_sir_tx  <= k[1];
			ir_pin_drive <= k[2];
			uart_tx      <= ~k[0];
			tick(2);
			chk(txd_pin, k[2] ? ((k[0] ^ k[3]) | k[1]) : !k[0]);
		end
		apb(1, 8'h04, 0);
	endtask

	// Receive polarity and loopback in medium mode, then receive switched off.
	task automatic s_rx();
		int k;
		for (k = 0; k < 16; k++)
		begin
			if (k[1:0] == 2'd0)
			begin
				apb(1, 8'h00, k[3] ? 32'h0000_0006 : 32'h0000_0002);
				apb(1, 8'h04, k[2] ? 32'h0000_0050 : 32'h0000_0010);
			end
			@(posedge mclk);
			rxd_pin      <= k[0];
			tx_shift_bit <= k[1];
			tick(2);
			chk(rx_serial, k[3] ? k[1] : (k[0] ^ k[2]));
		end
		apb(1, 8'h04, 0);
		tick(2);
		chk({rx_run, rx_serial}, 0);
	endtask

	// An underrun under each setting of the underrun action.
	task automatic s_under();
		int a;
		apb(1, 8'h00, 32'h0000_0003);
		for (a = 0; a < 2; a++)
		begin
			apb(1, 8'h04, a[0] ? 32'h0000_000c : 32'h0000_0008);
			@(posedge mclk);
			tx_underrun <= 1'b1;
			@(posedge mclk);
			tx_underrun <= 1'b0;
			#1;
			chk({tx_end_frame, tx_abort}, {~a[0], a[0]});
			tick(1);
			chk({tx_end_frame, tx_abort}, 0);
		end
		apb(1, 8'h04, 0);
	endtask

	// Offers one frame and records the entries it should leave in the buffer.
	task automatic frame(input logic [7:0] a, input int n, input logic kept);
		int i;
		if (kept)
			for (i = 0; i < n; i++)
				exp_q.push_back({i == n - 1, a + 8'(i)});
		far_u.send_frame(a, n);
	endtask

	// Pops one byte per entry with ready held high, as the DMA side does before it
	// packs words, compares each entry, then expects an empty buffer.
	task automatic drain();
		int t;
		@(posedge mclk);
		rx_out_ready <= 1'b1;
		#1;
		for (t = 0; t < 300 && exp_q.size() > 0; t++)
		begin
			if (rx_out_valid === 1'b1)
				chk(rx_out_data, exp_q.pop_front());
			tick(1);
		end
		chk(exp_q.size(), 0);
		// Looked at before ready drops, so a stray extra entry cannot slip out unseen.
		chk(rx_out_valid, 0);
		@(posedge mclk);
		rx_out_ready <= 1'b0;
		#1;
	endtask

	// Address filtering with a live rewrite, then a buffer filled until it refuses.
	task automatic s_filter();
		apb(1, 8'h00, 32'h0000_0002);
		frame(8'h11, 2, 0); // Receive is off, so the bytes are dropped.
		apb(1, 8'h08, 32'h0000_005a);
		apb(1, 8'h04, 32'h0000_0090);
		frame(8'h5a, 3, 1);
		frame(8'h33, 3, 0);
		frame(8'hff, 2, 1);
		apb(1, 8'h08, 32'h0000_0033);
		frame(8'h33, 1, 1);
		frame(8'h5a, 1, 0);
		drain();
		apb(1, 8'h04, 32'h0000_0010);
		frame(8'h77, 2, 1);
		fork
			frame(8'h40, 17, 1);
		join_none
		tick(40);
		chk({rx_byte_valid, rx_byte_ready}, 2'h2);
		drain();
	endtask

	// Reset for 20 cycles, then the scenarios in turn.
	initial
	begin
		repeat (20) @(posedge mclk);
		rst_b <= 1'b1;
		s_regs();
		s_mode();
		s_done();
		s_pin();
		s_rx();
		s_under();
		s_filter();
		complete_run();
	end

	// Watchdog: the sequence needs well under a thousand cycles, so this is ample margin.
	initial
	begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		complete_run();
	end
endmodule // infrared_link_control_bench
